// ### hw/vaop_defs.svh
// Offsets, field positions, reset values and counts of the video adjust output port
`ifndef VAOP_DEFS_SVH
`define VAOP_DEFS_SVH
`define VAOP_I2C_ADDR 7'h44
`define VAOP_OFS_BRIGHT 8'h01
`define VAOP_OFS_CONTRAST 8'h02
`define VAOP_OFS_HUE 8'h03
`define VAOP_OFS_SHARP 8'h04
`define VAOP_OFS_SAT 8'h05
`define VAOP_OFS_FORMAT 8'h16
`define VAOP_OFS_LAST 8'h1B
`define VAOP_RST_BRIGHT 8'h80
`define VAOP_RST_CONTRAST 8'hBD
`define VAOP_RST_HUE 8'h00
`define VAOP_RST_SHARP 8'h00
`define VAOP_RST_SAT 8'h9D
`define VAOP_RST_FORMAT 8'h00
`define VAOP_BIT_SETUP 7
`define VAOP_BIT_VSHARP_OFF 6
`define VAOP_BIT_EIGHT 0
`define VAOP_SETUP_NTSC 8'h49
`define VAOP_SETUP_PAL 8'h40
`define VAOP_HUE_LIM 8'h78
`define VAOP_PHASE_FULL 11'h5A0
`define VAOP_AGC_MIN 9'h008
`define VAOP_AGC_MAX 9'h080
`define VAOP_AGC_UNITY 8'h10
`define VAOP_CHROMA_ZERO 8'h80
`define VAOP_TOT_525_601 10'h35A
`define VAOP_TOT_625_601 10'h360
`define VAOP_TOT_525_SQ 10'h30C
`define VAOP_TOT_625_SQ 10'h3B0
`define VAOP_ACT_601 10'h2D0
`define VAOP_ACT_525_SQ 10'h280
`define VAOP_ACT_625_SQ 10'h300
`endif

// ### hw/vaop_pkg.sv
// Types shared by the video adjust output port
package vaop_pkg;
  typedef struct packed {
    logic valid;
    logic line_start;
    logic [7:0] luma;
    logic signed [7:0] chroma;
    logic signed [11:0] vdetail;
  } vaop_vid_in_t;
  typedef struct packed {
    logic [7:0] bright;
    logic [7:0] contrast;
    logic [7:0] hue;
    logic [7:0] sharp;
    logic [7:0] sat;
    logic [7:0] format;
  } vaop_ctrl_t;
  typedef struct packed {
    logic [7:0] luma_bus;
    logic [7:0] chroma_bus;
    logic sample_valid_flag;
    logic active_flag;
  } vaop_pix_out_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WR, I2C_RD} vaop_i2c_st_t;
endpackage

// ### hw/vaop_top.sv
// Video adjust output port: I2C controls, luma/chroma adjust, 16/8-bit pixel output
//
// Summary of operation
// [R1] Luma out equals (luma minus setup plus brightness) times contrast.
// [R2] Brightness register: low seven bits signed offset, top bit setup cancel.
// [R3] Setup bit one subtracts 73 from luma, zero subtracts 64.
// [R4] Brightness offset is signed, -64 darkest to +63 brightest.
// [R5] Brightness register resets to 80 hex.
// [R6] Contrast is unsigned 1.7 fixed point, register equals factor times 128.
// [R7] Contrast register resets to BD hex.
// [R8] Hue shifts burst phase reference, plus or minus 30 degrees, quarter steps.
// [R9] Hue register resets to zero, no rotation.
// [R10] Each luma band gain code: 00 x1, 01 x2, 10 x4, 11 x0.
// [R11] Vertical sharpness factor is 1 or 0, 1 after reset.
// [R12] Chroma at one sixteenth nominal kills colour and holds phase reference.
// [R13] Colour returns once chroma reaches one seventh of nominal.
// [R14] AGC gain clamps between 0.5 and 8.
// [R15] AGC gain changes by a bounded step per line.
// [R16] Saturation 1.7 factor scales chroma after AGC, resets to 9D hex.
// [R17] 16-bit mode: luma on luma bus, Cb then Cr on chroma bus.
// [R18] 16-bit mode: valid flag pulses for every converter output, blanking too; outputs past the line total get no pulse.
// [R19] 16-bit mode: active flag high only during active video.
// [R20] 8-bit mode: Cb, Y, Cr, Y on luma bus, active pixels only.
// [R21] 8-bit mode: active flag held high, valid marks each active byte.
// [R22] System supplies 24.54, 27 or 29.5 MHz clock in 8-bit mode.
// [R23] Per line totals/actives: 858/720, 864/720, 780/640, 944/768.
// [R24] Luma and chroma results saturate to eight bits.
`timescale 1ns/10ps
`include "vaop_defs.svh"
module vaop_top
  import vaop_pkg::*;
#(
  parameter logic [7:0] NOMINAL_AMP = 8'h40,
  parameter logic [8:0] AGC_STEP = 9'h001
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // I2C slave pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Decoded video from the rate converter and chroma loop
  input wire vaop_vid_in_t vid_in,
  input wire logic [7:0] burst_amp,
  input wire logic [10:0] burst_phase,
  // Chroma loop phase reference and colour killer state
  output logic [10:0] phase_ref,
  output logic color_killed,
  // Pixel output port
  output vaop_pix_out_t pix_out
);
  vaop_ctrl_t ctrl_q;
  vaop_i2c_st_t st_q;
  logic scl_q, sda_q, ack_q, rd_drive_q, rd_next_q, rw_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, rsh_q, ptr_q;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, wr_en;

  function automatic logic [7:0] reg_read(input vaop_ctrl_t c, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `VAOP_OFS_BRIGHT) r = c.bright;
    else if (a == `VAOP_OFS_CONTRAST) r = c.contrast;
    else if (a == `VAOP_OFS_HUE) r = c.hue;
    else if (a == `VAOP_OFS_SHARP) r = c.sharp;
    else if (a == `VAOP_OFS_SAT) r = c.sat;
    else if (a == `VAOP_OFS_FORMAT) r = c.format;
    return r;
  endfunction

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    return (p >= `VAOP_OFS_LAST) ? 8'h00 : p + 8'h01;
  endfunction

  // Pins are synchronous, so one stage of history is enough for edge detection
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign i2c_start = scl_i & scl_q & sda_q & ~sda_i;
  assign i2c_stop = scl_i & scl_q & ~sda_q & sda_i;
  assign wr_en = (st_q == I2C_WR) & scl_fall & (bit_q == 4'h8) & ~ack_q;
  assign sda_o = 1'b0;
  assign sda_oe = ack_q | (rd_drive_q & ~rsh_q[7]);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      st_q <= I2C_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rsh_q <= 8'h00;
      ptr_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      rd_drive_q <= 1'b0;
      rd_next_q <= 1'b0;
    end
    else if (i2c_start)
    begin
      st_q <= I2C_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      rd_drive_q <= 1'b0;
      rd_next_q <= 1'b0;
    end
    else if (i2c_stop)
    begin
      st_q <= I2C_IDLE;
      ack_q <= 1'b0;
      rd_drive_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        I2C_ADDR, I2C_PTR, I2C_WR:
        begin
          if (scl_rise && bit_q != 4'h8)
          begin
            sh_q <= {sh_q[6:0], sda_i};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_rise)
            bit_q <= 4'h0;
          else if (scl_fall && bit_q == 4'h8 && !ack_q)
          begin
            if (st_q == I2C_ADDR && sh_q[7:1] != `VAOP_I2C_ADDR)
              st_q <= I2C_IDLE;
            else
              ack_q <= 1'b1;
            if (st_q == I2C_ADDR)
              rw_q <= sh_q[0];
            if (st_q == I2C_PTR)
              ptr_q <= sh_q;
            if (st_q == I2C_WR)
              ptr_q <= ptr_inc(ptr_q);
          end
          else if (scl_fall && ack_q)
          begin
            ack_q <= 1'b0;
            if (st_q == I2C_ADDR && rw_q)
            begin
              st_q <= I2C_RD;
              rsh_q <= reg_read(ctrl_q, ptr_q);
              rd_drive_q <= 1'b1;
            end
            else
              st_q <= (st_q == I2C_ADDR) ? I2C_PTR : I2C_WR;
          end
        end
        I2C_RD:
        begin
          if (scl_fall && rd_next_q)
          begin
            rd_next_q <= 1'b0;
            rsh_q <= reg_read(ctrl_q, ptr_q);
            rd_drive_q <= 1'b1;
          end
          else if (scl_fall && bit_q == 4'h8)
            rd_drive_q <= 1'b0;
          else if (scl_fall && bit_q != 4'h0)
            rsh_q <= {rsh_q[6:0], 1'b0};
          else if (scl_rise && bit_q != 4'h8)
            bit_q <= bit_q + 4'h1;
          else if (scl_rise && sda_i)
            st_q <= I2C_IDLE;
          else if (scl_rise)
          begin
            bit_q <= 4'h0;
            ptr_q <= ptr_inc(ptr_q);
            rd_next_q <= 1'b1;
          end
        end
        default:
          bit_q <= 4'h0;
      endcase
    end

  // Control registers, written by the I2C write stage
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ctrl_q.bright <= `VAOP_RST_BRIGHT; // R5
      ctrl_q.contrast <= `VAOP_RST_CONTRAST; // R7
      ctrl_q.hue <= `VAOP_RST_HUE; // R9
      ctrl_q.sharp <= `VAOP_RST_SHARP; // R11
      ctrl_q.sat <= `VAOP_RST_SAT; // R16
      ctrl_q.format <= `VAOP_RST_FORMAT;
    end
    else if (wr_en)
    begin
      if (ptr_q == `VAOP_OFS_BRIGHT) ctrl_q.bright <= sh_q;
      else if (ptr_q == `VAOP_OFS_CONTRAST) ctrl_q.contrast <= sh_q;
      else if (ptr_q == `VAOP_OFS_HUE) ctrl_q.hue <= sh_q;
      else if (ptr_q == `VAOP_OFS_SHARP) ctrl_q.sharp <= sh_q;
      else if (ptr_q == `VAOP_OFS_SAT) ctrl_q.sat <= sh_q;
      else if (ptr_q == `VAOP_OFS_FORMAT) ctrl_q.format <= sh_q;
    end

  function automatic logic signed [13:0] band_gain(input logic signed [11:0] v,
                                                   input logic [1:0] c);
    logic signed [13:0] e;
    e = {{2{v[11]}}, v};
    case (c)
      2'b00: return e;
      2'b01: return e <<< 1;
      2'b10: return e <<< 2;
      default: return 14'sh0000;
    endcase
  endfunction

  function automatic logic [7:0] sat8(input logic signed [23:0] v);
    if (v < 0) return 8'h00; // R24
    else if (v > 24'sh00FF) return 8'hFF; // R24
    else return v[7:0];
  endfunction

  // Luma path: three-tap band split, per-band gain, then setup, brightness, contrast
  logic [7:0] y1_q, y2_q;
  logic signed [7:0] c1_q;
  logic signed [11:0] s0, s1, s2, lp, hp, mp;
  logic signed [13:0] ysh;
  logic signed [14:0] ladj;
  logic signed [23:0] lprod;
  logic [7:0] setup, luma_w, chroma_w;
  logic signed [25:0] cprod;
  logic signed [23:0] csum;
  assign s0 = {4'h0, vid_in.luma};
  assign s1 = {4'h0, y1_q};
  assign s2 = {4'h0, y2_q};
  assign lp = (s0 + (s1 <<< 1) + s2) >>> 2;
  assign hp = s1 - ((s0 + s2) >>> 1);
  assign mp = s1 - lp - hp;
  assign ysh = band_gain(lp, ctrl_q.sharp[1:0]) + band_gain(mp, ctrl_q.sharp[3:2]) // R10
             + band_gain(hp, ctrl_q.sharp[5:4]) // R10
             + (ctrl_q.sharp[`VAOP_BIT_VSHARP_OFF] ? 14'sh0000 : 14'(vid_in.vdetail)); // R11
  assign setup = ctrl_q.bright[`VAOP_BIT_SETUP] ? `VAOP_SETUP_NTSC : `VAOP_SETUP_PAL; // R3
  assign ladj = 15'(ysh) - $signed({7'h00, setup})
              + {{8{ctrl_q.bright[6]}}, ctrl_q.bright[6:0]}; // R1 R2 R4
  assign lprod = ladj * $signed({1'b0, ctrl_q.contrast}); // R1 R6
  assign luma_w = sat8(lprod >>> 7); // R24

  // Chroma path: AGC gain (4 fraction bits) then saturation (7 fraction bits)
  logic [7:0] agc_q;
  logic kill_q;
  logic [10:0] phase_q;
  assign cprod = c1_q * $signed({1'b0, agc_q}) * $signed({1'b0, ctrl_q.sat}); // R16
  assign csum = 24'(cprod >>> 11) + 24'sh0080;
  assign chroma_w = kill_q ? `VAOP_CHROMA_ZERO : sat8(csum); // R12 R24

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      y1_q <= 8'h00;
      y2_q <= 8'h00;
      c1_q <= 8'sh00;
    end
    else if (vid_in.valid)
    begin
      y1_q <= vid_in.luma;
      y2_q <= y1_q;
      c1_q <= vid_in.chroma;
    end

  // Loop gain moves one bounded step per line, so a burst glitch cannot jump it
  logic [8:0] agc_up, agc_dn;
  logic [15:0] amp_scaled;
  assign amp_scaled = burst_amp * agc_q;
  assign agc_up = {1'b0, agc_q} + AGC_STEP;
  assign agc_dn = {1'b0, agc_q} - AGC_STEP;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      agc_q <= `VAOP_AGC_UNITY;
    else if (vid_in.line_start) // R15
    begin
      // Full product width, so a large gain at strong burst cannot wrap and climb
      if (amp_scaled[15:4] < {4'h0, NOMINAL_AMP})
        agc_q <= (agc_up > `VAOP_AGC_MAX) ? 8'(`VAOP_AGC_MAX) : agc_up[7:0]; // R14
      else if (amp_scaled[15:4] > {4'h0, NOMINAL_AMP})
        agc_q <= ({1'b0, agc_q} < AGC_STEP + `VAOP_AGC_MIN) ? 8'(`VAOP_AGC_MIN)
               : agc_dn[7:0]; // R14
    end

  logic [11:0] amp16, amp7, nom12;
  assign amp16 = {burst_amp, 4'h0};
  assign amp7 = {4'h0, burst_amp} * 12'h007;
  assign nom12 = {4'h0, NOMINAL_AMP};
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      kill_q <= 1'b0;
    else if (vid_in.line_start)
    begin
      if (amp16 <= nom12)
        kill_q <= 1'b1; // R12
      else if (amp7 >= nom12)
        kill_q <= 1'b0; // R13
    end

  // Hue offsets the burst phase reference in quarter degrees; killer freezes it
  logic signed [7:0] hue_lim;
  logic signed [12:0] phase_sum;
  assign hue_lim = ($signed(ctrl_q.hue) > $signed(`VAOP_HUE_LIM)) ? `VAOP_HUE_LIM
                 : ($signed(ctrl_q.hue) < -$signed(`VAOP_HUE_LIM)) ? -`VAOP_HUE_LIM
                 : ctrl_q.hue;
  assign phase_sum = $signed({2'b00, burst_phase}) + 13'(hue_lim); // R8
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      phase_q <= 11'h000;
    else if (!kill_q) // R12
    begin
      if (phase_sum < 0)
        phase_q <= 11'(phase_sum + 13'(`VAOP_PHASE_FULL)); // R8
      else if (phase_sum >= 13'(`VAOP_PHASE_FULL))
        phase_q <= 11'(phase_sum - 13'(`VAOP_PHASE_FULL)); // R8
      else
        phase_q <= phase_sum[10:0]; // R8
    end
  assign phase_ref = phase_q;
  assign color_killed = kill_q;

  // Line sample counting for the selected standard
  function automatic logic [19:0] line_counts(input logic [1:0] std);
    case (std)
      2'b00: return {`VAOP_TOT_525_601, `VAOP_ACT_601}; // R23
      2'b01: return {`VAOP_TOT_625_601, `VAOP_ACT_601}; // R23
      2'b10: return {`VAOP_TOT_525_SQ, `VAOP_ACT_525_SQ}; // R23
      default: return {`VAOP_TOT_625_SQ, `VAOP_ACT_625_SQ}; // R23
    endcase
  endfunction

  logic [9:0] samp_q, tot, act;
  logic cb_next_q, eight, emit, in_act, y_pend_q;
  logic [7:0] y_hold_q;
  assign {tot, act} = line_counts(ctrl_q.format[2:1]);
  assign eight = ctrl_q.format[`VAOP_BIT_EIGHT];
  assign emit = vid_in.valid & (samp_q < tot); // R23
  assign in_act = samp_q >= tot - act; // R19

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      samp_q <= 10'h000;
      cb_next_q <= 1'b1;
    end
    else if (vid_in.line_start)
    begin
      samp_q <= 10'h000;
      cb_next_q <= 1'b1;
    end
    else if (emit)
    begin
      samp_q <= samp_q + 10'h001;
      if (!eight || in_act)
        cb_next_q <= ~cb_next_q; // R17 R20
    end

  // 8-bit mode sends the chroma byte first and the held luma byte next cycle;
  // the supported clocks leave a spare cycle between converter outputs
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      pix_out <= {8'h00, `VAOP_CHROMA_ZERO, 1'b0, 1'b0};
      y_pend_q <= 1'b0;
      y_hold_q <= 8'h00;
    end
    else if (eight)
    begin
      pix_out.active_flag <= 1'b1; // R21
      pix_out.chroma_bus <= `VAOP_CHROMA_ZERO;
      y_pend_q <= emit & in_act & ~y_pend_q;
      if (y_pend_q)
      begin
        pix_out.luma_bus <= y_hold_q; // R20
        pix_out.sample_valid_flag <= 1'b1; // R21
      end
      else if (emit && in_act)
      begin
        pix_out.luma_bus <= chroma_w; // R20
        y_hold_q <= luma_w;
        pix_out.sample_valid_flag <= 1'b1; // R21
      end
      else
        pix_out.sample_valid_flag <= 1'b0; // R20
    end
    else
    begin
      y_pend_q <= 1'b0;
      pix_out.sample_valid_flag <= emit; // R18
      if (emit)
      begin
        pix_out.luma_bus <= luma_w; // R17
        pix_out.chroma_bus <= chroma_w; // R17
        pix_out.active_flag <= in_act; // R19
      end
    end

  a_bright_reset: assert property (@(posedge clk) disable iff (!nrst) // R5
    !$past(nrst) |-> ctrl_q.bright == 8'h80 && ctrl_q.contrast == 8'hBD && ctrl_q.sat == 8'h9D)
    else $error("control reset values wrong");
  a_setup_value: assert property (@(posedge clk) disable iff (!nrst) // R3
    setup == (ctrl_q.bright[7] ? 8'd73 : 8'd64)) else $error("setup level wrong");
  a_agc_range: assert property (@(posedge clk) disable iff (!nrst) // R14
    agc_q >= 8'd8 && agc_q <= 8'd128) else $error("agc gain out of range");
  a_agc_hold: assert property (@(posedge clk) disable iff (!nrst) // R15
    !vid_in.line_start |=> $stable(agc_q)) else $error("agc changed inside a line");
  a_kill_chroma: assert property (@(posedge clk) disable iff (!nrst) // R12
    $past(kill_q) && $past(emit) && !$past(eight) |-> pix_out.chroma_bus == 8'h80)
    else $error("chroma not zero under colour killer");
  a_kill_release: assert property (@(posedge clk) disable iff (!nrst) // R13
    vid_in.line_start && amp7 >= nom12 && amp16 > nom12 |=> !kill_q)
    else $error("colour killer not released");
  a_eight_active: assert property (@(posedge clk) disable iff (!nrst) // R21
    $past(eight) |-> pix_out.active_flag) else $error("active low in 8-bit mode");
  a_byte_pair: assert property (@(posedge clk) disable iff (!nrst) // R20
    eight && emit && in_act && !y_pend_q |=> pix_out.sample_valid_flag ##1
    pix_out.sample_valid_flag && pix_out.luma_bus == $past(luma_w, 2))
    else $error("8-bit luma byte missing");
  a_valid_pulse: assert property (@(posedge clk) disable iff (!nrst) // R18
    !eight && !vid_in.line_start ##1 !eight |-> pix_out.sample_valid_flag == $past(emit))
    else $error("16-bit valid does not follow converter");
  a_line_total: assert property (@(posedge clk) disable iff (!nrst) // R23
    $past(emit) && $stable(ctrl_q.format) |-> samp_q <= tot) else $error("line overrun");
endmodule

// ### tb/vaop_capture_model.sv
// Capture processor model: keeps every flagged sample from the pixel port
`timescale 1ns/10ps
module vaop_capture_model
  import vaop_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pixel port of the device
  input wire vaop_pix_out_t pix
);
  vaop_pix_out_t got[$];
  // Blanking samples are kept too, so totals per line can be counted
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      got.delete();
    else if (pix.sample_valid_flag === 1'b1)
      got.push_back(pix);
  end
endmodule

// ### tb/video_adjust_output_port_tb.sv
// Self-checking bench for the video adjust output port
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module video_adjust_output_port_tb
  import vaop_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl = 1'b1;
  logic msda = 1'b1;
  logic sda_o, sda_oe, color_killed;
  logic [10:0] phase_ref, pr;
  logic [10:0] burst_phase = 11'h000;
  logic [7:0] burst_amp = 8'hFF;
  logic [7:0] rd[5];
  logic a;
  vaop_vid_in_t vid_in = '0;
  vaop_pix_out_t pix_out;
  wire sda_i = msda & ~sda_oe;
  int br = 128, ct = 189, sat = 157, gl = 1, agc = 16, std, killed, cmp_c = 1, eight;
  int prev_y, prev_c, n_errors, checked, cycles;
  int tot[4] = '{858, 864, 780, 944};
  int act[4] = '{720, 720, 640, 768};
  int ey[$], ec[$], ea[$];
  logic [7:0] hv[6] = '{8'h00, 8'h78, 8'h88, 8'h7F, 8'h14, 8'hEC};
  int bp[6] = '{700, 100, 100, 100, 1430, 5};
  int hx[6] = '{700, 220, 1420, 220, 10, 1425};

  vaop_top dut (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .vid_in(vid_in), .burst_amp(burst_amp), .burst_phase(burst_phase),
    .phase_ref(phase_ref), .color_killed(color_killed), .pix_out(pix_out));
  vaop_capture_model cap (.clk(clk), .nrst(nrst), .pix(pix_out));

  always #20 clk = ~clk;

  task automatic finish_test();
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well past the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic hw();
    repeat (4) @(negedge clk);
  endtask

  task automatic ibit(input logic b, output logic r);
    msda = b;
    hw();
    scl = 1'b1;
    hw();
    r = sda_i;
    scl = 1'b0;
    hw();
  endtask

  task automatic istart();
    msda = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    msda = 1'b0;
    hw();
    scl = 1'b0;
    hw();
  endtask

  task automatic istop();
    msda = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    msda = 1'b1;
    hw();
  endtask

  task automatic ibyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      ibit(d[i], r);
    ibit(1'b1, r);
    ack = ~r;
  endtask

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    logic a0, a1, a2;
    istart();
    ibyte(8'h88, a0);
    ibyte(ofs, a1);
    ibyte(d, a2);
    istop();
    `CHK({a0, a1, a2}, 3'b111)
  endtask

  // Burst read; the pointer runs on by itself, last byte gets no acknowledge
  task automatic reg_rd(input logic [7:0] ofs, input int n);
    logic a0, a1, a2, r;
    istart();
    ibyte(8'h88, a0);
    ibyte(ofs, a1);
    istart();
    ibyte(8'h89, a2);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
        ibit(1'b1, rd[k][i]);
      ibit(k == n - 1, r);
    end
    istop();
    `CHK({a0, a1, a2}, 3'b111)
  endtask

  function automatic int lum(int y);
    int e;
    e = y * gl - (br >= 128 ? 73 : 64) + (((br & 127) ^ 64) - 64);
    e = (e * ct) >>> 7;
    return e < 0 ? 0 : (e > 255 ? 255 : e);
  endfunction

  function automatic int chr(int c);
    int e;
    e = 128 + ((c * agc * sat) >>> 11);
    return killed ? 128 : (!cmp_c ? -1 : (e > 255 ? 255 : (e < 0 ? 0 : e)));
  endfunction

  task automatic check_out();
    `CHK(cap.got.size(), ey.size())
    for (int i = 0; i < ey.size() && i < cap.got.size(); i++)
    begin
      if (ey[i] >= 0) `CHK(cap.got[i].luma_bus, ey[i])
      if (ec[i] >= 0) `CHK(cap.got[i].chroma_bus, ec[i])
      `CHK(cap.got[i].active_flag, ea[i])
    end
    ey.delete();
    ec.delete();
    ea.delete();
    cap.got.delete();
  endtask

  // One line: the model follows the per-line gain and killer update
  task automatic send_line(input int n, input int gap, input int fy);
    int y, c, s0;
    @(negedge clk);
    vid_in.line_start = 1'b1;
    @(negedge clk);
    vid_in.line_start = 1'b0;
    if (burst_amp * 16 <= 64) killed = 1;
    else if (burst_amp * 7 >= 64) killed = 0;
    if (burst_amp * agc / 16 > 64 && agc > 8) agc--;
    else if (burst_amp * agc / 16 < 64 && agc < 128) agc++;
    s0 = eight ? tot[std] - act[std] : 0;
    for (int i = 0; i < n; i++)
    begin
      y = fy >= 0 ? fy : $urandom_range(255);
      c = int'($urandom_range(255)) - 128;
      vid_in.luma = 8'(y);
      vid_in.chroma = 8'(c);
      vid_in.vdetail = 12'($urandom);
      vid_in.valid = 1'b1;
      if (i < tot[std] && i >= s0)
      begin
        ey.push_back(i == s0 ? -1 : (eight ? chr(prev_c) : lum(prev_y)));
        ec.push_back(eight ? 128 : (i == 0 ? -1 : chr(prev_c)));
        ea.push_back(eight || i >= tot[std] - act[std]);
        if (eight)
        begin
          ey.push_back(i == s0 ? -1 : lum(prev_y));
          ec.push_back(128);
          ea.push_back(1);
        end
      end
      prev_y = y;
      prev_c = c;
      @(negedge clk);
      if (gap > 0)
      begin
        vid_in.valid = 1'b0;
        repeat (gap) @(negedge clk);
      end
    end
    vid_in.valid = 1'b0;
    repeat (4) @(negedge clk);
    check_out();
  endtask

  initial
  begin
    void'($urandom(55826));
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    reg_rd(8'h01, 5);
    foreach (rd[k])
      `CHK(rd[k], k == 0 ? 8'h80 : k == 1 ? 8'hBD : k == 4 ? 8'h9D : 8'h00)
    reg_rd(8'h1A, 3);
    for (int k = 0; k < 3; k++)
      `CHK(rd[k], 8'h00)
    istart();
    ibyte(8'h90, a);
    istop();
    `CHK(a, 1'b0)
    reg_wr(8'h04, 8'h40);
    foreach (hv[k])
    begin
      reg_wr(8'h03, hv[k]);
      burst_phase = 11'(bp[k]);
      repeat (3) @(negedge clk);
      `CHK(phase_ref, 11'(hx[k]))
    end
    repeat (10) send_line(8, 0, -1);
    burst_amp = 8'h03;
    send_line(8, 0, -1);
    `CHK(color_killed, 1'b1)
    pr = phase_ref;
    burst_phase = 11'h123;
    repeat (3) @(negedge clk);
    `CHK(phase_ref, pr)
    burst_amp = 8'h09;
    send_line(8, 0, -1);
    `CHK(color_killed, 1'b1)
    cmp_c = 0;
    burst_amp = 8'h0A;
    send_line(8, 0, -1);
    `CHK(color_killed, 1'b0)
    burst_amp = 8'hFF;
    repeat (14) send_line(8, 0, -1);
    agc = 8;
    cmp_c = 1;
    for (int s = 0; s < 4; s++)
    begin
      br = $urandom_range(255);
      ct = $urandom_range(255);
      sat = $urandom_range(255);
      reg_wr(8'h01, 8'(br));
      reg_wr(8'h02, 8'(ct));
      reg_wr(8'h05, 8'(sat));
      reg_wr(8'h16, 8'(s << 1));
      std = s;
      send_line(tot[s] + 3, 0, -1);
    end
    br = 0;
    ct = 128;
    reg_wr(8'h01, 8'h00);
    reg_wr(8'h02, 8'h80);
    // Constant luma leaves only the low band, so each code shows directly
    for (int g = 0; g < 4; g++)
    begin
      reg_wr(8'h04, 8'(64 + g * 21));
      gl = g == 0 ? 1 : g == 1 ? 2 : g == 2 ? 4 : 0;
      send_line(12, 0, 70);
    end
    gl = 1;
    reg_wr(8'h04, 8'h40);
    reg_wr(8'h16, 8'h01);
    std = 0;
    eight = 1;
    `CHK(pix_out.active_flag, 1'b1)
    send_line(tot[0] + 2, 1, -1);
    `CHK(pix_out.active_flag, 1'b1)
    `CHK(pix_out.chroma_bus, 8'h80)
    finish_test();
  end
endmodule
